//--- logic/ogcc_checker.v
`timescale 1ns/1ns
`include "ogcc_regs.vh"
// Operation
// - Override needs position or speed control
// - Override scale factors must all exceed zero
// - Scaled override speed within axis maximum
// - Gear denominator zero is refused
// - Master reference select must be in range
// - Master axis only 1-32 or 37-42
// - Master axis differs from slave axis
// - Master axis must be ready
// - Encoder master refused on common parameter error
// - Sync gear-in refused with torque master
// - Running gear slave overspeed raises error
// - Gear disengage only while gearing
// - Sync target speed not below current speeds
// - Sync must reach slave position in time
module ogcc_checker #(
  parameter AXW = 6,
  parameter SPW = 32
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst,
  input wire i_ce,
  // Command
  input wire i_cmd_valid,
  input wire [1:0] i_cmd_code,
  input wire [AXW-1:0] i_cmd_axis,
  // Override parameters (8.8 fixed point scales)
  input wire [15:0] i_velocity_scale,
  input wire [15:0] i_accel_scale,
  input wire [15:0] i_jerk_scale,
  // Gear parameters
  input wire [15:0] i_gear_den,
  input wire [1:0] i_master_reference_select,
  input wire [AXW-1:0] i_master_axis,
  input wire [SPW-1:0] i_sync_target_speed,
  input wire [SPW-1:0] i_master_lead_distance,
  input wire [SPW-1:0] i_slave_sync_distance,
  // Axis state
  input wire [2:0] i_axis_mode,
  input wire [SPW-1:0] i_axis_speed,
  input wire [SPW-1:0] i_axis_max_speed,
  input wire [SPW-1:0] i_gear_speed,
  input wire [SPW-1:0] i_slave_speed_limit,
  input wire [SPW-1:0] i_master_speed,
  input wire i_master_ready,
  input wire i_master_torque,
  input wire i_common_param_err,
  // Results
  output reg o_done,
  output reg o_accept,
  output reg [2:0] o_axis_mode,
  output reg [15:0] o_err_code,
  output reg o_err_flag
);
  wire [15:0] gear_err;
  reg [15:0] err_d;
  reg [2:0] mode_d;
  reg [SPW+15:0] scaled;
  reg [2*SPW-1:0] slave_time;
  reg [2*SPW-1:0] master_time;
  reg run_over;

  // ----------------------------------------
  // Gear parameter checks
  // ----------------------------------------
  ogcc_gear_check #(
    .AXW(AXW)
  ) u_gear (
    .i_is_sync(i_cmd_code == `OGCC_CMD_SYNC_GEAR_IN),
    .i_den(i_gear_den),
    .i_src(i_master_reference_select),
    .i_master(i_master_axis),
    .i_slave(i_cmd_axis),
    .i_master_ready(i_master_ready),
    .i_master_torque(i_master_torque),
    .i_common_param_err(i_common_param_err),
    .o_err(gear_err)
  );

  // ----------------------------------------
  // Command evaluation
  // ----------------------------------------
  always @* begin
    scaled = i_axis_speed * i_velocity_scale;
    // Cross-multiplied time compare avoids a divider: dist_s/v_s > dist_m/v_m
    slave_time = i_slave_sync_distance * i_master_speed;
    master_time = i_master_lead_distance * i_sync_target_speed;
    run_over = (o_axis_mode == `OGCC_MODE_GEAR) && (i_gear_speed > i_slave_speed_limit);
    err_d = `OGCC_ERR_NONE;
    mode_d = o_axis_mode;
    case (i_cmd_code)
      `OGCC_CMD_OVERRIDE: begin
        // Gearing is neither position nor speed control, so it refuses an override too
        if (o_axis_mode == `OGCC_MODE_GEAR ||
            (i_axis_mode != `OGCC_MODE_POSITION && i_axis_mode != `OGCC_MODE_SPEED)) begin
          err_d = `OGCC_ERR_OVR_MODE;
        end else if (i_velocity_scale == 16'h0000 || i_accel_scale == 16'h0000 ||
                     i_jerk_scale == 16'h0000) begin
          err_d = `OGCC_ERR_OVR_FACTOR;
        end else if (scaled[SPW+7:8] > i_axis_max_speed || scaled[SPW+15:SPW+8] != 8'h00) begin
          err_d = `OGCC_ERR_OVR_MAXSPD;
        end
      end
      `OGCC_CMD_GEAR_IN: begin
        err_d = gear_err;
        if (gear_err == `OGCC_ERR_NONE) begin
          mode_d = `OGCC_MODE_GEAR;
        end
      end
      `OGCC_CMD_SYNC_GEAR_IN: begin
        err_d = gear_err;
        if (gear_err != `OGCC_ERR_NONE) begin
          err_d = gear_err;
        end else if (i_sync_target_speed < i_axis_speed || i_sync_target_speed < i_gear_speed) begin
          err_d = `OGCC_ERR_SYNC_SPD;
        end else if (slave_time > master_time) begin
          err_d = `OGCC_ERR_SYNC_REACH;
        end else begin
          mode_d = `OGCC_MODE_GEAR;
        end
      end
      `OGCC_CMD_GEAR_OUT: begin
        if (o_axis_mode != `OGCC_MODE_GEAR) begin
          err_d = `OGCC_ERR_GEAR_OUT;
        end else begin
          mode_d = `OGCC_MODE_IDLE;
        end
      end
      default: begin
        err_d = `OGCC_ERR_NONE;
      end
    endcase
    if (err_d != `OGCC_ERR_NONE) begin
      mode_d = o_axis_mode;
    end
  end

  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_done <= 1'b0;
      o_accept <= 1'b0;
      o_axis_mode <= `OGCC_MODE_IDLE;
      o_err_code <= `OGCC_ERR_NONE;
      o_err_flag <= 1'b0;
    end else if (i_ce) begin
      o_done <= i_cmd_valid;
      o_accept <= i_cmd_valid && (err_d == `OGCC_ERR_NONE);
      if (i_cmd_valid) begin
        if (err_d != `OGCC_ERR_NONE) begin
          o_err_code <= err_d;
          o_err_flag <= 1'b1;
        end else begin
          o_axis_mode <= mode_d;
          o_err_code <= `OGCC_ERR_NONE;
          o_err_flag <= 1'b0;
        end
      end else if (run_over) begin
        // Overspeed drops the axis out of gearing so the slave is not driven on
        o_err_code <= `OGCC_ERR_GEAR_SPD;
        o_err_flag <= 1'b1;
        o_axis_mode <= `OGCC_MODE_IDLE;
      end
    end
  end
endmodule

//--- logic/ogcc_regs.vh
`ifndef OGCC_REGS_VH
`define OGCC_REGS_VH
// ----------------------------------------
// Error codes
// ----------------------------------------
`define OGCC_ERR_NONE 16'h0000
`define OGCC_ERR_OVR_MODE 16'h10c0
`define OGCC_ERR_OVR_FACTOR 16'h10c1
`define OGCC_ERR_OVR_MAXSPD 16'h10c2
`define OGCC_ERR_GEAR_DEN 16'h10d0
`define OGCC_ERR_GEAR_SRC 16'h10d1
`define OGCC_ERR_GEAR_AXIS 16'h10d2
`define OGCC_ERR_GEAR_SAME 16'h10d3
`define OGCC_ERR_GEAR_READY 16'h10d4
`define OGCC_ERR_GEAR_ENC 16'h10d5
`define OGCC_ERR_GEAR_TORQ 16'h10d6
`define OGCC_ERR_GEAR_SPD 16'h10d7
`define OGCC_ERR_GEAR_OUT 16'h10d8
`define OGCC_ERR_SYNC_SPD 16'h10d9
`define OGCC_ERR_SYNC_REACH 16'h10da
// ----------------------------------------
// Commands
// ----------------------------------------
`define OGCC_CMD_OVERRIDE 2'h0
`define OGCC_CMD_GEAR_IN 2'h1
`define OGCC_CMD_SYNC_GEAR_IN 2'h2
`define OGCC_CMD_GEAR_OUT 2'h3
// ----------------------------------------
// Axis modes
// ----------------------------------------
`define OGCC_MODE_IDLE 3'h0
`define OGCC_MODE_POSITION 3'h1
`define OGCC_MODE_SPEED 3'h2
`define OGCC_MODE_TORQUE 3'h3
`define OGCC_MODE_GEAR 3'h4
// ----------------------------------------
// Ranges
// ----------------------------------------
`define OGCC_AXIS_LO1 6'h01
`define OGCC_AXIS_HI1 6'h20
`define OGCC_AXIS_LO2 6'h25
`define OGCC_AXIS_HI2 6'h2a
`define OGCC_SRC_MAX 2'h1
`define OGCC_SRC_ENCODER 2'h1
`endif

//--- logic/ogcc_gear_check.v
`timescale 1ns/1ns
`include "ogcc_regs.vh"
// Combinational gear parameter checks, first failure in documented order wins
module ogcc_gear_check #(
  parameter AXW = 6
) (
  // Command
  input wire i_is_sync,
  input wire [15:0] i_den,
  input wire [1:0] i_src,
  input wire [AXW-1:0] i_master,
  input wire [AXW-1:0] i_slave,
  // Master state
  input wire i_master_ready,
  input wire i_master_torque,
  input wire i_common_param_err,
  // Result
  output reg [15:0] o_err
);
  function axis_ok;
    input [AXW-1:0] a;
    begin
      axis_ok = ((a >= `OGCC_AXIS_LO1) && (a <= `OGCC_AXIS_HI1)) ||
                ((a >= `OGCC_AXIS_LO2) && (a <= `OGCC_AXIS_HI2));
    end
  endfunction

  always @* begin
    o_err = `OGCC_ERR_NONE;
    if (i_den == 16'h0000) begin
      o_err = `OGCC_ERR_GEAR_DEN;
    end else if (i_src > `OGCC_SRC_MAX) begin
      o_err = `OGCC_ERR_GEAR_SRC;
    end else if (i_src != `OGCC_SRC_ENCODER && !axis_ok(i_master)) begin
      o_err = `OGCC_ERR_GEAR_AXIS;
    end else if (i_src != `OGCC_SRC_ENCODER && i_master == i_slave) begin
      o_err = `OGCC_ERR_GEAR_SAME;
    end else if (i_src != `OGCC_SRC_ENCODER && !i_master_ready) begin
      o_err = `OGCC_ERR_GEAR_READY;
    end else if (i_src == `OGCC_SRC_ENCODER && i_common_param_err) begin
      o_err = `OGCC_ERR_GEAR_ENC;
    end else if (i_is_sync && i_src != `OGCC_SRC_ENCODER && i_master_torque) begin
      o_err = `OGCC_ERR_GEAR_TORQ;
    end
  end
endmodule

//--- sim/ogcc_checker_asserts.sv
`timescale 1ns/1ns
module ogcc_checker_asserts (
  // Command side
  input logic i_core_clk,
  input logic i_rst,
  input logic i_ce,
  input logic i_cmd_valid,
  input logic [1:0] i_cmd_code,
  input logic [2:0] i_axis_mode,
  input logic [15:0] i_gear_den,
  input logic [31:0] i_gear_speed,
  input logic [31:0] i_slave_speed_limit,
  // Results
  input logic o_done,
  input logic o_accept,
  input logic [2:0] o_axis_mode,
  input logic [15:0] o_err_code
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic tk;
  logic gear;
  assign tk = i_ce && i_cmd_valid;
  assign gear = o_axis_mode == 3'h4;
  chk_done_answer: assert property (tk |=> o_done) else $error("no done");
  chk_done_cause: assert property (o_done && $past(i_ce) |-> $past(i_cmd_valid)) else $error("stray done");
  chk_reject_holds: assert property (tk |=> o_accept == (o_err_code == 16'h0)
    && (o_accept || o_axis_mode == $past(o_axis_mode))) else $error("reject moved mode");
  chk_ovr_mode: assert property (tk && i_cmd_code == 2'h0 && (gear || !(i_axis_mode inside {3'h1, 3'h2}))
    |=> o_err_code == 16'h10c0) else $error("override taken");
  chk_den_zero: assert property (tk && ^i_cmd_code && i_gear_den == 16'h0
    |=> o_err_code == 16'h10d0) else $error("zero den taken");
  chk_gear_disengage_command_idle: assert property (tk && i_cmd_code == 2'h3 && !gear
    |=> o_err_code == 16'h10d8) else $error("disengage taken");
  chk_gear_disengage_command_exit: assert property (tk && i_cmd_code == 2'h3 && gear
    |=> o_accept && o_axis_mode == 3'h0) else $error("disengage refused");
  chk_overspeed_trip: assert property (!tk && i_ce && gear && i_gear_speed > i_slave_speed_limit
    |=> o_err_code == 16'h10d7 && o_axis_mode == 3'h0) else $error("overspeed missed");
endmodule
bind ogcc_checker ogcc_checker_asserts u_chk (.i_core_clk, .i_rst, .i_ce, .i_cmd_valid, .i_cmd_code, .i_gear_den,
  .i_axis_mode, .i_gear_speed, .i_slave_speed_limit, .o_done, .o_accept, .o_axis_mode, .o_err_code);

//--- sim/ogcc_host_model.sv
`timescale 1ns/1ns
module ogcc_host_model (
  // Clock
  input logic i_core_clk,
  // Command strobe
  output logic o_valid,
  output logic [1:0] o_code
);
  initial o_valid = 0;
  initial o_code = 0;
  // Released code shows its inverse so a stale value never looks live
  task automatic issue(input logic [1:0] k);
    @(posedge i_core_clk);
    #2 o_valid = 1;
    o_code = k;
    @(posedge i_core_clk);
    #2 o_valid = 0;
    o_code = ~k;
  endtask
endmodule

//--- sim/override_gear_command_checker_bench.sv
`timescale 1ns/1ns
module override_gear_command_checker_bench;
  logic i_core_clk = 0, i_rst = 1, v, rdy = 1, t = 0, e = 0;
  logic [1:0] c, src = 0;
  logic [2:0] m = 0, am = 0;
  logic ce = 1;
  logic [31:0] mx = '1;
  logic [5:0] ax = 5, ma = 1;
  logic [15:0] den = 1;
  logic [31:0] r = 39, s0 = 0, s1 = 0, s2 = 0, s3 = 0, s4 = 0, s5 = 0, lim = '1;
  wire [21:0] seen;
  logic [5:0] tbl [9] = '{6'h20, 6'h21, 6'h24, 6'h25, 6'h2a, 6'h2b, 6'h05, 6'h00, 6'h01};
  int errors = 0, samples_checked = 0;
  initial forever #20 i_core_clk = ~i_core_clk;
  ogcc_host_model h (.i_core_clk, .o_valid(v), .o_code(c));
  ogcc_checker DUT (.i_core_clk, .i_rst, .i_ce(ce), .i_cmd_valid(v), .i_cmd_code(c), .i_cmd_axis(ax),
    .i_velocity_scale(r[15:0]), .i_accel_scale(r[31:16]), .i_jerk_scale(r[23:8]), .i_gear_den(den),
    .i_master_reference_select(src), .i_master_axis(ma), .i_sync_target_speed(s0), .i_master_lead_distance(s5),
    .i_slave_sync_distance(s3), .i_axis_mode(am), .i_axis_speed(s1), .i_axis_max_speed(mx), .i_gear_speed(s2),
    .i_slave_speed_limit(lim), .i_master_speed(s4), .i_master_ready(rdy), .i_master_torque(t),
    .i_common_param_err(e), .o_done(seen[21]), .o_accept(seen[20]), .o_err_flag(seen[19]),
    .o_axis_mode(seen[18:16]), .o_err_code(seen[15:0]));
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Mirrors the check order; m tracks the mode the device should hold
  function automatic logic [21:0] want(input logic [1:0] k);
    logic [15:0] x;
    logic [47:0] p;
    x = 0;
    p = s1 * r[15:0];
    if (k == 0) begin
      if (m == 4 || !(am inside {1, 2})) x = 16'h10c0;
      else if (r[15:0] == 0 || r[31:16] == 0 || r[23:8] == 0) x = 16'h10c1;
      else if (p[47:40] != 0 || p[39:8] > mx) x = 16'h10c2;
    end
    else if (k == 3) x = m == 4 ? 16'h0 : 16'h10d8;
    else if (den == 0) x = 16'h10d0;
    else if (src > 1) x = 16'h10d1;
    else if (src == 0 && !(ma inside {[1:32], [37:42]})) x = 16'h10d2;
    else if (src == 0 && ma == ax) x = 16'h10d3;
    else if (src == 0 && !rdy) x = 16'h10d4;
    else if (src == 1 && e) x = 16'h10d5;
    else if (k == 2 && src == 0 && t) x = 16'h10d6;
    else if (k == 2 && (s0 < s1 || s0 < s2)) x = 16'h10d9;
    else if (k == 2 && s3 * s4 > s5 * s0) x = 16'h10da;
    if (x == 0 && k != 0) m = k == 3 ? 3'h0 : 3'h4;
    return {1'b1, x == 0, x != 0, m, x};
  endfunction
  task automatic check(input logic [21:0] got, input logic [21:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [1:0] k);
    h.issue(k);
    check(seen, want(k));
  endtask
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_core_clk);
    #2 i_rst = 0;
    check(seen, 22'h0);
    $display("reset test done");
    run(3);
    run(0);
    foreach (tbl[i]) begin
      ma = tbl[i];
      run(1);
    end
    run(0);
    run(3);
    run(1);
    s2 = 1;
    lim = 0;
    @(posedge i_core_clk);
    #2 check(seen, {6'h08, 16'h10d7});
    m = 0;
    lim = '1;
    // Clock enable low: the command is not taken and the error stays readable
    ce = 0;
    h.issue(3);
    check(seen, {6'h08, 16'h10d7});
    ce = 1;
    am = 1;
    r = 32'h00000101;
    run(0);
    r = 32'h01010101;
    s1 = 4;
    mx = 0;
    run(0);
    mx = '1;
    run(0);
    $display("corner test done");
    repeat (600) begin
      r = nx(r);
      {ma, ax, rdy, t, e, den[1:0]} = r[16:0];
      src = r[19:17] == 0 ? 2'h2 : {1'b0, r[20]};
      am = r[23:21];
      r = nx(r);
      mx = {26'h0, r[31:26]};
      {s0[3:0], s1[3:0], s2[3:0], s3[3:0], s4[3:0], s5[3:0]} = r[23:0];
      run(r[25:24]);
    end
    $display("random test done");
    tally_and_finish;
  end
endmodule
